// File: hdl/sme_pkg.sv
// Shared types and constants of the message end detector.
// Assumes a 100 MHz system clock and characters from a
// UART receiver on the same clock.
package sme_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // Longest measurable gap, 8 s
    localparam int unsigned GAP_MAX_MS = 8000;

    // Reset values the host should load, and the maximum length cap
    localparam logic [15:0] MSG_MS_DEF = 16'h00c8;
    localparam logic [15:0] RESP_MS_DEF = 16'h00c8;
    localparam logic [15:0] GAP_BITS_DEF = 16'h000c;
    localparam logic [10:0] MAX_LEN_DEF = 11'h000;
    localparam logic [10:0] MAX_LEN_LIMIT = 11'h400;

    // Length field sizes
    localparam logic [1:0] LSZ_1 = 2'h0;
    localparam logic [1:0] LSZ_2 = 2'h1;
    localparam logic [1:0] LSZ_4 = 2'h2;

    // Positions in enable and cause vectors
    localparam int unsigned C_MSG = 0;
    localparam int unsigned C_RESP = 1;
    localparam int unsigned C_GAP = 2;
    localparam int unsigned C_MAX = 3;
    localparam int unsigned C_LEN = 4;
    localparam int unsigned C_CHR = 5;
    localparam int unsigned C_SEQ = 6;
    localparam int unsigned N_CAUSE = 7;
    localparam int unsigned SEQ_N = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RECV = 3'h4
    } sme_state_t;

    // One received character
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sme_char_t;

    // Host configuration of all end criteria
    typedef struct packed {
        logic [N_CAUSE-1:0] en;
        logic [15:0] msg_ms;
        logic [15:0] resp_ms;
        logic [15:0] gap_bits;
        logic [15:0] bit_cycles;
        logic [10:0] max_len;
        logic [10:0] len_pos;
        logic [1:0] len_size;
        logic [15:0] len_extra;
        logic [7:0] end_char;
        logic [SEQ_N*8-1:0] seq_val;
        logic [SEQ_N-1:0] seq_care;
    } sme_cfg_t;

    // Completion event
    typedef struct packed {
        logic done;
        logic [10:0] count;
        logic [N_CAUSE-1:0] cause;
    } sme_evt_t;

endpackage : sme_pkg

// File: hdl/sme_detector.sv
// Receive-side message end detector for a serial port.
// Every end criterion is checked in one next-state process.
// Assumes rx characters and tx_done come from logic on sys_clk
// and that the host holds the configuration stable per message.
`timescale 1ns/1ps
module sme_detector
    import sme_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Characters from the line receiver
    input wire sme_char_t rx,
    // Pulse at the end of each transmission
    input wire logic tx_done,
    // Configuration
    input wire sme_cfg_t cfg,
    // Characters kept for the message
    output sme_char_t msg_chr,
    output logic msg_last,
    // Status and completion
    output logic receiving,
    output sme_evt_t evt
);

    // Refuse a millisecond divider that cannot be counted
    if (MS_CYC < 1 || MS_CYC > 32'h7fffffff) begin : g_chk
        $error("sme_detector: MS_CYC out of range");
    end

    // The first compared position is searched in a 3-bit index
    if (SEQ_N < 1 || SEQ_N > 7) begin : g_chk_seq
        $error("sme_detector: SEQ_N out of range");
    end

    // The 8 s gap ceiling must fit its 13-bit ms counter
    if (GAP_MAX_MS > 32'h1fff) begin : g_chk_gap
        $error("sme_detector: GAP_MAX_MS too large");
    end

    // All state of the block in one register; the timers
    // run while idle too, which costs a little switching
    // but keeps every timer register free of a state enable
    // and makes every timer start a plain reload
    typedef struct packed {
        sme_state_t st;
        logic [31:0] ms_pre;
        logic [15:0] ms_cnt;
        logic [12:0] gap_ms;
        logic [15:0] bit_pre;
        logic [16:0] gap_bits;
        logic [10:0] cnt;
        logic [31:0] len_val;
        logic [33:0] target;
        logic tgt_ok;
        logic [SEQ_N*8-1:0] hist;
        sme_evt_t evt;
        sme_char_t out;
        logic out_last;
    } sme_reg_t;

    // Prescaler end point and the gap ceiling in ms; the
    // ceiling bounds a gap that bit ticks alone could not reach
    localparam logic [31:0] MS_LAST = 32'(MS_CYC - 1);
    localparam logic [12:0] GAP_MS_LIM = 13'(GAP_MAX_MS);

    sme_reg_t r_r;
    sme_reg_t r_nxt;

    // Length field width in bytes; the spare size code
    // reads as four bytes, so a mis-set field still closes
    // rather than leaving the length criterion dead
    function automatic logic [10:0] len_bytes(input logic [1:0] sz);
        unique case (sz)
            LSZ_1: len_bytes = 11'h001;
            LSZ_2: len_bytes = 11'h002;
            LSZ_4: len_bytes = 11'h004;
            default: len_bytes = 11'h004;
        endcase
    endfunction : len_bytes

    // Index of the first compared position, SEQ_N if none
    // Leading don't-cares thus shorten the condition, trailing ones do not
    function automatic logic [2:0] seq_first(input logic [SEQ_N-1:0] care);
        seq_first = 3'(SEQ_N);
        for (int i = SEQ_N - 1; i >= 0; i--) begin
            if (care[i]) begin
                seq_first = 3'(i);
            end
        end
    endfunction : seq_first

    // Next-state logic
    // Every criterion looks at the same cycle, so the first
    // one met ends the message, and several met together
    // all report in the cause
    always_comb begin
        logic ms_tick;
        logic bit_tick;
        logic in_msg;
        logic [10:0] cnt_new;
        logic [10:0] fld_end;
        logic [31:0] len_new;
        logic [33:0] tgt_new;
        logic tgt_ok_new;
        logic [SEQ_N*8-1:0] hist_new;
        logic [2:0] sf;
        logic seq_hit;
        logic [N_CAUSE-1:0] fire;
        logic [10:0] max_eff;
        ms_tick = 1'b0;
        bit_tick = 1'b0;
        in_msg = 1'b0;
        cnt_new = '0;
        fld_end = '0;
        len_new = '0;
        tgt_new = '0;
        tgt_ok_new = 1'b0;
        hist_new = '0;
        sf = '0;
        seq_hit = 1'b0;
        fire = '0;
        max_eff = '0;
        r_nxt = r_r;
        r_nxt.evt.done = 1'b0;
        r_nxt.out.valid = 1'b0;
        r_nxt.out_last = 1'b0;

        // Free millisecond prescaler; restarted when the response or message timer starts
        // Counts saturate so a long idle spell never wraps short
        ms_tick = (r_r.ms_pre >= MS_LAST);
        r_nxt.ms_pre = ms_tick ? '0 : r_r.ms_pre + 32'h1;
        if (ms_tick && r_r.ms_cnt != 16'hffff) begin
            r_nxt.ms_cnt = r_r.ms_cnt + 16'h1;
        end
        if (ms_tick && r_r.gap_ms != GAP_MS_LIM) begin
            r_nxt.gap_ms = r_r.gap_ms + 13'h1;
        end

        // Bit time ticks from the baud divider
        // A bit_cycles of zero wraps to the slowest divider,
        // so the gap stays long rather than firing at once
        bit_tick = (r_r.bit_pre >= cfg.bit_cycles - 16'h1);
        r_nxt.bit_pre = bit_tick ? '0 : r_r.bit_pre + 16'h1;
        if (bit_tick && !r_r.gap_bits[16]) begin
            r_nxt.gap_bits = r_r.gap_bits + 17'h1;
        end

        // Idle: a finished transmission arms the response timer
        // Only from idle, so a late pulse never cuts an open message
        if (r_r.st == ST_IDLE && tx_done && cfg.en[C_RESP]) begin
            r_nxt.st = ST_WAIT;
            r_nxt.ms_pre = '0;
            r_nxt.ms_cnt = '0;
        end

        // No start in time: reception ends with nothing kept
        // A character in that cycle wins and opens the message
        if (r_r.st == ST_WAIT && !rx.valid && r_r.ms_cnt >= cfg.resp_ms) begin
            fire[C_RESP] = 1'b1;
        end

        // Time based ends while a message is open
        // The message timer runs from the opening character, not the last
        if (r_r.st == ST_RECV) begin
            in_msg = 1'b1;
            if (cfg.en[C_MSG] && r_r.ms_cnt >= cfg.msg_ms) begin
                fire[C_MSG] = 1'b1;
            end
            // Gap must be exceeded, capped at 8 s
            // Never on a character cycle, whose arrival resets the gap
            if (cfg.en[C_GAP] && !rx.valid &&
                (r_r.gap_bits > {1'b0, cfg.gap_bits} || r_r.gap_ms >= GAP_MS_LIM)) begin
                fire[C_GAP] = 1'b1;
            end
        end

        // Character path: the first one outside a message opens it
        // Start detection lies upstream; any character there starts one
        if (rx.valid) begin
            if (r_r.st != ST_RECV) begin
                r_nxt.st = ST_RECV;
                r_nxt.ms_pre = '0;
                r_nxt.ms_cnt = '0;
                cnt_new = 11'h001;
                len_new = '0;
                tgt_new = '0;
                tgt_ok_new = 1'b0;
                hist_new = {{(SEQ_N-1)*8{1'b0}}, rx.data};
            end else begin
                cnt_new = (r_r.cnt == 11'h7ff) ? r_r.cnt : r_r.cnt + 11'h1;
                len_new = r_r.len_val;
                tgt_new = r_r.target;
                tgt_ok_new = r_r.tgt_ok;
                hist_new = {r_r.hist[(SEQ_N-1)*8-1:0], rx.data};
            end
            // Silence timer restarts on each character
            // Both gap measures restart so the 8 s ceiling tracks the same silence
            r_nxt.bit_pre = '0;
            r_nxt.gap_bits = '0;
            r_nxt.gap_ms = '0;

            // Length field shifts in most significant byte first
            // A zero value and no tail end the message on the last field byte
            fld_end = cfg.len_pos + len_bytes(cfg.len_size) - 11'h1;
            if (cfg.len_pos != 11'h0 && cnt_new >= cfg.len_pos && cnt_new <= fld_end) begin
                len_new = {len_new[23:0], rx.data};
                if (cnt_new == fld_end) begin
                    // Field end plus value plus uncounted tail
                    tgt_new = {23'h0, fld_end} + {2'b00, len_new} + {18'h0, cfg.len_extra};
                    tgt_ok_new = 1'b1;
                end
            end
            if (cfg.en[C_LEN] && tgt_ok_new && {23'h0, cnt_new} == tgt_new) begin
                fire[C_LEN] = 1'b1;
            end

            // Maximum count; zero leaves it idle, larger than the cap acts as the cap
            max_eff = (cfg.max_len > MAX_LEN_LIMIT) ? MAX_LEN_LIMIT : cfg.max_len;
            if (cfg.en[C_MAX] && max_eff != 11'h0 && cnt_new >= max_eff) begin
                fire[C_MAX] = 1'b1;
            end

            // Single terminator
            if (cfg.en[C_CHR] && rx.data == cfg.end_char) begin
                fire[C_CHR] = 1'b1;
            end

            // Masked sequence, newest character is position five
            // No match until enough characters cover the first compared position
            sf = seq_first(cfg.seq_care);
            seq_hit = (sf < 3'(SEQ_N)) && (cnt_new >= 11'(SEQ_N - sf));
            for (int p = 0; p < SEQ_N; p++) begin
                if (cfg.seq_care[p] &&
                    hist_new[8*(SEQ_N-1-p) +: 8] != cfg.seq_val[8*p +: 8]) begin
                    seq_hit = 1'b0;
                end
            end
            if (cfg.en[C_SEQ] && seq_hit) begin
                fire[C_SEQ] = 1'b1;
            end

            // Every character goes out with the message
            // No buffer here: the host side stores what it is handed
            r_nxt.cnt = cnt_new;
            r_nxt.len_val = len_new;
            r_nxt.target = tgt_new;
            r_nxt.tgt_ok = tgt_ok_new;
            r_nxt.hist = hist_new;
            r_nxt.out.valid = 1'b1;
            r_nxt.out.data = rx.data;
            in_msg = 1'b1;
        end

        // Any criterion closes the message and reports it
        // Several criteria in one cycle all show in the cause
        if (|fire) begin
            r_nxt.st = ST_IDLE;
            r_nxt.evt.done = 1'b1;
            r_nxt.evt.count = in_msg ? r_nxt.cnt : 11'h0;
            r_nxt.evt.cause = fire;
            r_nxt.out_last = rx.valid;
            r_nxt.cnt = '0;
            r_nxt.tgt_ok = 1'b0;
        end
    end

    // State register
    // The reset branch loads constants only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_r <= '{st: ST_IDLE, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs straight from flip-flops
    // receiving decodes registered state, so it only moves on an edge
    assign msg_chr = r_r.out;
    assign msg_last = r_r.out_last;
    assign receiving = (r_r.st == ST_RECV);
    assign evt = r_r.evt;

endmodule : sme_detector

// File: verification/sme_monitor.sv
// Port checker of the message end detector.
// Assumes one clock domain with the async active-low reset.
`timescale 1ns/1ps
module sme_monitor
    import sme_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Inputs
    input wire sme_char_t rx,
    input wire logic tx_done,
    input wire sme_cfg_t cfg,
    // Outputs
    input wire sme_char_t msg_chr,
    input wire logic msg_last,
    input wire logic receiving,
    input wire sme_evt_t evt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Every char kept, whatever ends the message
    property p_echo; rx.valid |=> msg_chr.valid && msg_chr.data == $past(rx.data); endproperty
    a_echo: assert property (p_echo) else $error("char not echoed");
    property p_endchr; rx.valid && cfg.en[C_CHR] && rx.data == cfg.end_char |=> evt.done && evt.cause[C_CHR]; endproperty
    a_endchr: assert property (p_endchr) else $error("end char missed");
    property p_last; msg_last |-> msg_chr.valid && evt.done; endproperty
    a_last: assert property (p_last) else $error("last without done");
    // Count must not drift between events
    property p_hold; !evt.done |-> $stable(evt.count); endproperty
    a_hold: assert property (p_hold) else $error("count moved");
    property p_cause; evt.done |-> evt.cause != 0 && (evt.cause & ~cfg.en) == 0; endproperty
    a_cause: assert property (p_cause) else $error("bad cause");
    property p_max; evt.done && evt.cause[C_MAX] |->
        evt.count == (cfg.max_len > MAX_LEN_LIMIT ? MAX_LEN_LIMIT : cfg.max_len); endproperty
    a_max: assert property (p_max) else $error("max length count");
    property p_resp; evt.done && evt.cause[C_RESP] |-> evt.count == 0 && !msg_chr.valid; endproperty
    a_resp: assert property (p_resp) else $error("response count");
    property p_close; evt.done && !rx.valid |=> !receiving; endproperty
    a_close: assert property (p_close) else $error("message left open");
    // Main end paths seen
    c_len: cover property (evt.done && evt.cause[C_LEN]);
    c_seq: cover property (evt.done && evt.cause[C_SEQ]);
    c_msg: cover property (evt.done && evt.cause[C_MSG]);
    c_resp: cover property (evt.done && evt.cause[C_RESP]);
endmodule : sme_monitor
bind sme_detector sme_monitor u_mon (.sys_clk, .reset_n, .rx, .tx_done, .cfg, .msg_chr, .msg_last,
    .receiving, .evt);

// File: verification/sme_peer.sv
// Model of the remote device sending characters.
// Assumes callers run just after a rising edge.
`timescale 1ns/1ps
module sme_peer
    import sme_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Characters to the detector
    output sme_char_t rx
);
    initial rx = '{valid: 1'b0, data: 8'h00};
    // One char per cycle; calls may follow back to back
    task automatic send(input logic [7:0] d);
        rx = '{valid: 1'b1, data: d};
        @(posedge sys_clk);
        #1;
    endtask : send
    // Idle line flips data so no stale char looks valid
    task automatic quiet();
        rx = '{valid: 1'b0, data: ~rx.data};
    endtask : quiet
endmodule : sme_peer

// File: verification/test_serial_message_end_detector.sv
// Testbench of the message end detector.
// Assumes the peer model drives rx; short ms prescaler.
`timescale 1ns/1ps
module test_serial_message_end_detector;
    import sme_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic tx_done = 1'b0;
    sme_cfg_t cfg = '0;
    sme_char_t rx;
    sme_char_t msg_chr;
    logic msg_last;
    logic receiving;
    sme_evt_t evt;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    sme_peer u_peer (.sys_clk(sys_clk), .rx(rx));
    sme_detector #(.MS_CYC(10)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .rx(rx), .tx_done(tx_done),
        .cfg(cfg), .msg_chr(msg_chr), .msg_last(msg_last), .receiving(receiving), .evt(evt));
    // Hang guard far above the longest test
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step
    // Bounded wait for the completion pulse
    task automatic wait_done();
        n = 0;
        while (evt.done !== 1'b1 && n < 500) begin
            step();
            n++;
        end
    endtask : wait_done
    task automatic cfg_set(input logic [6:0] en);
        cfg = '0;
        cfg.en = en;
        cfg.msg_ms = MSG_MS_DEF;
        cfg.resp_ms = RESP_MS_DEF;
        cfg.gap_bits = GAP_BITS_DEF;
        cfg.bit_cycles = 16'h0001;
        cfg.end_char = 8'h0d;
    endtask : cfg_set
    // End char and max length together, messages back to back
    task automatic t_max();
        cfg_set(7'h28);
        cfg.max_len = 11'h003;
        u_peer.send(8'h41);
        check(evt.done, 1'b0);
        u_peer.send(8'h0d);
        check({evt.count, evt.cause, msg_last}, {11'h002, 7'h20, 1'b1});
        for (int i = 0; i < 3; i++) begin
            u_peer.send(8'h41 + 8'(i));
            check(evt.done, i == 2);
        end
        check({evt.count, evt.cause}, {11'h003, 7'h08});
        u_peer.quiet();
        step();
        $display("test max length done");
    endtask : t_max
    // Length field of 1, 2, 4 and spare-code 4 bytes at position 2, tail of 0 or 1
    task automatic t_len();
        int nb;
        int ext;
        for (int s = 0; s < 4; s++) begin
            nb = (s == 0) ? 1 : (s == 1) ? 2 : 4;
            ext = s % 2;
            cfg_set(7'h10);
            cfg.len_pos = 11'h002;
            cfg.len_size = 2'(s);
            cfg.len_extra = 16'(ext);
            for (int i = 1; i <= nb + 3 + ext; i++) begin
                u_peer.send(i == nb + 1 ? 8'h02 : 8'h00);
                check(evt.done, i == nb + 3 + ext);
            end
            check(evt.count, 11'(nb + 3 + ext));
            u_peer.quiet();
            step();
        end
        $display("test length field done");
    endtask : t_len
    // Positions 2 and 3 compared; leading dropped, trailing kept; zero max stays idle
    task automatic t_seq();
        cfg_set(7'h48);
        cfg.seq_val = 40'h00007a7a00;
        cfg.seq_care = 5'h06;
        for (int i = 0; i < 4; i++) begin
            u_peer.send(i < 2 ? 8'h7a : 8'h01);
            check(evt.done, i == 3);
        end
        check({evt.count, evt.cause}, {11'h004, 7'h40});
        u_peer.quiet();
        step();
        $display("test end sequence done");
    endtask : t_seq
    // Timers: message 2 ms, gap 3 bit ticks, response 1 ms
    task automatic t_time();
        cfg_set(7'h01);
        cfg.msg_ms = 16'h0002;
        u_peer.send(8'h41);
        u_peer.quiet();
        wait_done();
        check({n >= 19 && n <= 23, evt.count, evt.cause}, {1'b1, 11'h001, 7'h01});
        step();
        cfg_set(7'h04);
        cfg.gap_bits = 16'h0002;
        cfg.bit_cycles = 16'h0003;
        u_peer.send(8'h41);
        u_peer.quiet();
        repeat (6) step();
        check(receiving, 1'b1);
        u_peer.send(8'h42);
        u_peer.quiet();
        wait_done();
        check({n >= 8 && n <= 12, evt.count, evt.cause}, {1'b1, 11'h002, 7'h04});
        step();
        cfg_set(7'h22);
        cfg.resp_ms = 16'h0001;
        tx_done = 1'b1;
        step();
        tx_done = 1'b0;
        wait_done();
        check({n <= 22, evt.count, evt.cause}, {1'b1, 11'h000, 7'h02});
        step();
        // A character while waiting opens the message instead
        tx_done = 1'b1;
        step();
        tx_done = 1'b0;
        u_peer.send(8'h41);
        u_peer.send(8'h0d);
        check({evt.count, evt.cause}, {11'h002, 7'h20});
        u_peer.quiet();
        step();
        $display("test timers done");
    endtask : t_time
    // Reset in mid-message drops it; the next message counts from one
    task automatic t_reset();
        cfg_set(7'h20);
        cfg.end_char = 8'h3b;
        u_peer.send(8'h41);
        u_peer.send(8'h0d);
        check({evt.done, receiving}, 2'b01);
        u_peer.quiet();
        reset_n = 1'b0;
        step();
        check({evt, receiving, msg_chr}, '0);
        reset_n = 1'b1;
        u_peer.send(8'h42);
        check({evt.done, receiving, msg_chr}, {1'b0, 1'b1, 1'b1, 8'h42});
        u_peer.send(8'h3b);
        check({evt.count, evt.cause, msg_last}, {11'h002, 7'h20, 1'b1});
        u_peer.quiet();
        step();
        $display("test reset done");
    endtask : t_reset
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        check({evt, receiving, msg_chr}, '0);
        t_max();
        t_len();
        t_seq();
        t_time();
        t_reset();
        finish_test();
    end
endmodule : test_serial_message_end_detector
